/* File: common/step_cfg_pkg.sv */
/*
 * Constants, tables and carrier types for the step/direction command
 * and switch configuration block.
 * Assumes a 10 MHz system clock and a 32-bit classic Wishbone master.
 */
package step_cfg_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 100;
    localparam int IDLE_TIME_US    = 1000000;   // Idle delay, 1 s
    localparam int IDLE_CYCLES_DEF = IDLE_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int PULSE_MIN_NS    = 2500;      // Far side pulse width
    localparam int DIR_SETUP_NS    = 5000;      // Far side dir setup
    localparam int SYNC_SETTLE     = 3;         // Cycles before latch

    // ----------------------------------------------------------------
    // Register map (byte addresses) and fields
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_CFG_CUR = 8'h04;
    localparam logic [7:0] ADDR_CFG_RES = 8'h08;
    localparam logic [7:0] ADDR_STATUS  = 8'h0c;
    localparam logic [7:0] ADDR_POS     = 8'h10;
    localparam logic [7:0] ADDR_EFF     = 8'h14;
    localparam int CTRL_DUAL = 0;
    localparam int CTRL_FALL = 1;
    localparam int CTRL_SRC  = 2;
    localparam int CTRL_CONF = 3;
    localparam logic [3:0] CTRL_RST = 4'h0;

    // Pin positions in the synchronised input vector; SW_FULL is the bit in the switch snapshot
    localparam int S_STEP = 0;
    localparam int S_DIR  = 1;
    localparam int S_ENA  = 2;
    localparam int S_SW   = 3;
    localparam int SW_FULL = 4;

    // ----------------------------------------------------------------
    // Current (tenths of an ampere) and resolution tables
    // ----------------------------------------------------------------
    localparam logic [6:0] CUR_DEFAULT = 7'h1e;  // Plain default
    localparam logic [6:0] CUR_MIN     = 7'h0a;
    localparam logic [6:0] CUR_MAX     = 7'h50;
    localparam logic [15:0][6:0] CUR_TBL = {
        7'h50, 7'h4d, 7'h49, 7'h45, 7'h40, 7'h3e, 7'h39, 7'h35,
        7'h31, 7'h2d, 7'h28, 7'h24, 7'h20, 7'h1d, 7'h19, CUR_DEFAULT};
    localparam logic [15:0] RES_MIN = 16'h00c8;
    localparam logic [15:0] RES_MAX = 16'hc800;
    localparam logic [7:0][15:0] RES_TBL = {
        16'h4e20, 16'h2710, 16'h1f40, 16'h0fa0,
        16'h07d0, 16'h03e8, 16'h3200, 16'h0190};

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_WAIT  = 2'b00,
        ST_LATCH = 2'b01,
        ST_RUN   = 2'b11
    } cfg_state_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_t;

endpackage : step_cfg_pkg

/* File: rtl/step_cfg.sv */
/*
 * Step/direction command decoding, switch bank configuration, idle
 * current reduction and a Wishbone register slave, all in one module.
 * Assumes pins are asynchronous to clk_sys_i and the switches are
 * stable across reset; a high switch input means the switch is ON.
 */
// Our own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
module step_cfg
    import step_cfg_pkg::*;
#(
    parameter int IDLE_CYCLES = IDLE_CYCLES_DEF
) (
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        sys_rst_i,
    // Command pins
    input  wire logic        step_pulse_input_i,
    input  wire logic        direction_input_i,
    input  wire logic        drive_enable_input_i,
    // Switch bank
    input  wire logic        current_select_bit0_i,
    input  wire logic        current_select_bit1_i,
    input  wire logic        current_select_bit2_i,
    input  wire logic        current_select_bit3_i,
    input  wire logic        standstill_full_select_i,
    input  wire logic        microstep_select_bit0_i,
    input  wire logic        microstep_select_bit1_i,
    input  wire logic        microstep_select_bit2_i,
    // Register bus
    input  wire wb_req_t     wb_req_i,
    output wb_rsp_t          wb_rsp_o,
    // Motion and power stage
    output logic             step_o,
    output logic             dir_o,
    output logic             power_enable_o,
    output logic [6:0]       phase_current_o,
    output logic [15:0]      resolution_o
);

    localparam logic [23:0] IDLE_LIM = 24'(IDLE_CYCLES);

    typedef struct packed {
        logic [10:0] s1;
        logic [10:0] s2;
        logic [10:0] s3;
        logic [10:0] filt;
        cfg_state_t  st;
        logic [1:0]  cnt;
        logic [7:0]  sw;
        logic [3:0]  ctrl;
        logic [6:0]  cfg_cur;
        logic [15:0] cfg_res;
        logic        step;
        logic        dir;
        logic        enable;
        logic        idle;
        logic [23:0] idle_cnt;
        logic [31:0] pos;
        logic [6:0]  dyn;
        logic [6:0]  phase;
        logic [15:0] res;
        logic        ack;
        logic [31:0] rdat;
    } state_t;

    state_t q;
    state_t d;
    logic [10:0] pins;
    logic        edge_sel;
    logic        step_ev;
    logic        ccw_ev;
    logic        wr;
    logic [31:0] wdat;
    logic [31:0] rd;

    // ----------------------------------------------------------------
    // Byte-lane merge for writes
    // ----------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // Pins gathered into one vector
    assign pins = {microstep_select_bit2_i, microstep_select_bit1_i,
                   microstep_select_bit0_i, standstill_full_select_i,
                   current_select_bit3_i, current_select_bit2_i,
                   current_select_bit1_i, current_select_bit0_i,
                   drive_enable_input_i, direction_input_i,
                   step_pulse_input_i};

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        rd = 32'h0;
        wdat = 32'h0;
        // Three-stage synchroniser, change taken when stages 2 and 3 agree
        d.s1 = pins;
        d.s2 = q.s1;
        d.s3 = q.s2;
        for (int i = 0; i < 11; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                d.filt[i] = q.s3[i];
            end
        end
        // Active edge: rising by default, sourcing and falling flip it
        edge_sel = q.ctrl[CTRL_FALL] ^ q.ctrl[CTRL_SRC];
        step_ev = (d.filt[S_STEP] != q.filt[S_STEP])
                  && (d.filt[S_STEP] == !edge_sel);
        ccw_ev = q.ctrl[CTRL_DUAL] && (d.filt[S_DIR] != q.filt[S_DIR])
                 && (d.filt[S_DIR] == !edge_sel);
        d.step = step_ev || ccw_ev;
        if (q.ctrl[CTRL_DUAL]) begin
            d.dir = ccw_ev;
        end else begin
            d.dir = d.filt[S_DIR];
        end
        if (d.step) begin
            d.pos = d.dir ? q.pos - 32'h1 : q.pos + 32'h1;
        end
        // Enable polarity follows signal type
        d.enable = d.filt[S_ENA] ^ q.ctrl[CTRL_SRC];
        // Switches latched once the synchroniser has settled
        case (q.st)
            ST_WAIT: begin
                d.cnt = q.cnt + 2'h1;
                if (q.cnt == 2'(SYNC_SETTLE - 1)) begin
                    d.st = ST_LATCH;
                end
            end
            ST_LATCH: begin
                // Registered filter still lags here, take this cycle's
                d.sw = d.filt[S_SW +: 8];
                d.st = ST_RUN;
            end
            ST_RUN: begin
                d.st = ST_RUN;
            end
            default: begin
                d.st = ST_WAIT;
            end
        endcase
        // Dynamic current and resolution from switches or registers
        if (q.ctrl[CTRL_CONF]) begin
            d.dyn = q.cfg_cur;
            d.res = q.cfg_res;
        end else begin
            d.dyn = CUR_TBL[q.sw[3:0]];
            d.res = RES_TBL[~q.sw[7:5]];
        end
        // Idle timer restarted by every step
        if (d.step) begin
            d.idle_cnt = 24'h0;
            d.idle = 1'b0;
        end else if (q.idle_cnt == IDLE_LIM) begin
            d.idle = 1'b1;
        end else begin
            d.idle_cnt = q.idle_cnt + 24'h1;
        end
        // Half current at standstill unless the full switch is ON
        if (q.idle && !q.sw[SW_FULL]) begin
            d.phase = {1'b0, q.dyn[6:1]};
        end else begin
            d.phase = q.dyn;
        end
        // Wishbone slave: ack one cycle after request, dropped after
        wr = wb_req_i.cyc && wb_req_i.stb && !q.ack && wb_req_i.we;
        d.ack = wb_req_i.cyc && wb_req_i.stb && !q.ack;
        case (wb_req_i.adr)
            ADDR_CTRL:    rd = {28'h0, q.ctrl};
            ADDR_CFG_CUR: rd = {25'h0, q.cfg_cur};
            ADDR_CFG_RES: rd = {16'h0, q.cfg_res};
            ADDR_STATUS:  rd = {8'h0, q.sw, 1'b0, q.phase, 4'h0,
                                q.dir, q.idle, q.st == ST_RUN, q.enable};
            ADDR_POS:     rd = q.pos;
            ADDR_EFF:     rd = {9'h0, q.dyn, q.res};
            default:      rd = 32'h0;
        endcase
        d.rdat = d.ack ? rd : 32'h0;
        if (wr) begin
            wdat = merge(rd, wb_req_i.dat, wb_req_i.sel);
            case (wb_req_i.adr)
                ADDR_CTRL: begin
                    d.ctrl = wdat[3:0];
                end
                ADDR_CFG_CUR: begin
                    if (wdat[6:0] >= CUR_MIN && wdat[6:0] <= CUR_MAX
                        && wdat[31:7] == 25'h0) begin
                        d.cfg_cur = wdat[6:0];
                    end
                end
                ADDR_CFG_RES: begin
                    if (wdat[15:0] >= RES_MIN && wdat[15:0] <= RES_MAX
                        && wdat[31:16] == 16'h0) begin
                        d.cfg_res = wdat[15:0];
                    end
                end
                default: begin
                    d.ctrl = q.ctrl;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            q <= '0;
            q.st <= ST_WAIT;
            q.ctrl <= CTRL_RST;
            q.cfg_cur <= CUR_DEFAULT;
            q.cfg_res <= RES_TBL[0];
            q.dyn <= CUR_DEFAULT;
            q.phase <= CUR_DEFAULT;
            q.res <= RES_TBL[0];
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign wb_rsp_o = '{ack: q.ack, dat: q.rdat};
    assign step_o = q.step;
    assign dir_o = q.dir;
    assign power_enable_o = q.enable;
    assign phase_current_o = q.phase;
    assign resolution_o = q.res;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_rise_step;
        !q.ctrl[CTRL_DUAL] && !q.ctrl[CTRL_FALL] && !q.ctrl[CTRL_SRC]
        && $rose(q.filt[S_STEP]) && $stable(q.ctrl);
    endsequence

    property p_sd_step;
        s_rise_step |-> q.step && (q.pos != $past(q.pos));
    endproperty
    a_sd_step: assert property (p_sd_step)
        else $error("rising step edge gave no microstep");

    property p_cw;
        q.ctrl[CTRL_DUAL] && q.step && !q.dir
        |-> $changed(q.filt[S_STEP]) && q.pos == $past(q.pos) + 32'h1;
    endproperty
    a_cw: assert property (p_cw)
        else $error("clockwise step without step input change");

    property p_dir_level;
        !q.ctrl[CTRL_DUAL] && q.step |-> q.dir == q.filt[S_DIR];
    endproperty
    a_dir_level: assert property (p_dir_level)
        else $error("step direction differs from direction input");

    property p_ccw;
        q.ctrl[CTRL_DUAL] && q.dir
        |-> q.step && $changed(q.filt[S_DIR])
            && q.pos == $past(q.pos) - 32'h1;
    endproperty
    a_ccw: assert property (p_ccw)
        else $error("counter-clockwise step not from direction input");

    property p_enable;
        $stable(q.ctrl) |-> q.enable == (q.filt[S_ENA]
                                         ^ q.ctrl[CTRL_SRC]);
    endproperty
    a_enable: assert property (p_enable)
        else $error("power enable polarity wrong");

    property p_reset_mode;
        disable iff (1'b0) sys_rst_i |=> q.ctrl == CTRL_RST && !q.step;
    endproperty
    a_reset_mode: assert property (p_reset_mode)
        else $error("mode not at default after reset");

    property p_cur_code;
        q.st == ST_RUN && !q.ctrl[CTRL_CONF] && $stable(q.ctrl)
        |=> q.dyn == CUR_TBL[q.sw[3:0]];
    endproperty
    a_cur_code: assert property (p_cur_code)
        else $error("dynamic current does not match switch code");

    property p_res_code;
        q.st == ST_RUN && !q.ctrl[CTRL_CONF] && $stable(q.ctrl)
        |=> q.res == RES_TBL[~q.sw[7:5]];
    endproperty
    a_res_code: assert property (p_res_code)
        else $error("resolution does not match switch code");

    property p_standstill;
        q.idle |=> q.phase == ($past(q.sw[SW_FULL]) ? $past(q.dyn)
                               : {1'b0, $past(q.dyn[6:1])});
    endproperty
    a_standstill: assert property (p_standstill)
        else $error("standstill current wrong");

    property p_idle;
        q.step |-> !q.idle ##1 (!q.idle && !q.step) [*2];
    endproperty
    a_idle: assert property (p_idle)
        else $error("idle reached too soon after a step");

    property p_conf_range;
        q.ctrl[CTRL_CONF] && $stable(q.ctrl)
        |=> q.res >= RES_MIN && q.res <= RES_MAX
            && q.dyn >= CUR_MIN && q.dyn <= CUR_MAX;
    endproperty
    a_conf_range: assert property (p_conf_range)
        else $error("configured setting out of range");

    property p_latch;
        q.st == ST_RUN |=> $stable(q.sw) && q.st == ST_RUN;
    endproperty
    a_latch: assert property (p_latch)
        else $error("switch snapshot changed while running");

endmodule : step_cfg

/* File: sim/pulse_gen.sv */
/*
 * Pulse generator model driving the step and direction pins.
 * Assumes the bench calls send() from one process at a time.
 */
`timescale 1ns/1ps
module pulse_gen (
    // Clock and mode
    input  wire logic clk_i,
    input  wire logic dual_i,
    input  wire logic fall_i,
    // Command pins
    output logic      step_pin_o,
    output logic      dir_pin_o
);
    // --------------------------------------------------------------
    // Pins and pulse task
    // --------------------------------------------------------------
    // Pins start idle low
    initial begin
        step_pin_o = 1'b0;
        dir_pin_o  = 1'b0;
    end

    // One pulse; idle level is the inverse of the active edge
    task automatic send(input logic ccw);
        logic idle;
        // Mode is read after the edge so a mode set just before is seen
        @(posedge clk_i);
        idle = fall_i;
        step_pin_o <= idle;
        dir_pin_o  <= dual_i ? idle : ccw;
        repeat (55) @(posedge clk_i);
        if (dual_i && ccw) begin
            dir_pin_o <= ~idle;
        end else begin
            step_pin_o <= ~idle;
        end
        repeat (30) @(posedge clk_i);
        step_pin_o <= idle;
        dir_pin_o  <= dual_i ? idle : ccw;
        repeat (30) @(posedge clk_i);
    endtask : send
endmodule : pulse_gen

/* File: sim/tb.sv */
/*
 * Self-checking bench for step_cfg: switch decode, step modes,
 * enable polarity, idle current and configured mode.
 * Assumes pulse_gen as the far side and a short idle count.
 */
`timescale 1ns/1ps
module tb;
    import step_cfg_pkg::*;
    localparam int IDLE_N = 200;
    localparam logic [6:0] CUR_EXP [16] = '{CUR_DEFAULT, 7'h19, 7'h1d,
        7'h20, 7'h24, 7'h28, 7'h2d, 7'h31, 7'h35, 7'h39, 7'h3e, 7'h40,
        7'h45, 7'h49, 7'h4d, 7'h50};
    localparam logic [15:0] RES_EXP [8] = '{16'h0190, 16'h3200,
        16'h03e8, 16'h07d0, 16'h0fa0, 16'h1f40, 16'h2710, 16'h4e20};
    logic        clk_sys_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        ena_pin   = 1'b1;
    logic [7:0]  sw        = 8'h00;
    logic        dual      = 1'b0;
    logic        fall      = 1'b0;
    wb_req_t     req       = '0;
    wb_rsp_t     rsp;
    logic        step_pin, dir_pin, step, dir, pwr;
    logic [6:0]  phase;
    logic [15:0] res;
    logic [7:0]  pick;
    logic [31:0] exp_val[$];
    logic [31:0] exp_msk[$];
    logic        exp_dir[$];
    int          failures = 0;
    int          checks_done = 0;

    // Clock
    always #50 clk_sys_i = ~clk_sys_i;

    // --------------------------------------------------------------
    // Design and far side
    // --------------------------------------------------------------
    step_cfg #(.IDLE_CYCLES(IDLE_N)) uut (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .step_pulse_input_i(step_pin), .direction_input_i(dir_pin),
        .drive_enable_input_i(ena_pin),
        .current_select_bit0_i(sw[0]), .current_select_bit1_i(sw[1]),
        .current_select_bit2_i(sw[2]), .current_select_bit3_i(sw[3]),
        .standstill_full_select_i(sw[4]),
        .microstep_select_bit0_i(sw[5]), .microstep_select_bit1_i(sw[6]),
        .microstep_select_bit2_i(sw[7]),
        .wb_req_i(req), .wb_rsp_o(rsp), .step_o(step), .dir_o(dir),
        .power_enable_o(pwr), .phase_current_o(phase),
        .resolution_o(res));
    pulse_gen pg (.clk_i(clk_sys_i), .dual_i(dual), .fall_i(fall),
        .step_pin_o(step_pin), .dir_pin_o(dir_pin));

    // --------------------------------------------------------------
    // Tasks
    // --------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Classic cycle; d is write data or expected read data
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d, input logic [31:0] m);
        int n;
        exp_val.push_back(d);
        exp_msk.push_back(we ? 32'h0 : m);
        @(posedge clk_sys_i);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf,
                 dat: (we ? d : 32'h0)};
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (rsp.ack !== 1'b1 && n < 20);
        req <= '0;
        if (n >= 20) begin
            failures++;
            report_and_stop();
        end
    endtask : wb

    // Sends n pulses, bit k of pat set means counter-clockwise
    task automatic steps(input logic [3:0] pat, input int n);
        for (int k = 0; k < n; k++) begin
            exp_dir.push_back(pat[k]);
            pg.send(pat[k]);
        end
    endtask : steps

    task automatic ena_chk(input logic pin, input logic exp);
        @(posedge clk_sys_i);
        ena_pin <= pin;
        repeat (8) @(posedge clk_sys_i);
        check(pwr, exp);
    endtask : ena_chk

    // Reset with a switch setting, then decode and idle checks
    task automatic do_reset(input logic [7:0] s);
        logic [6:0] dyn;
        dyn = CUR_EXP[s[3:0]];
        @(posedge clk_sys_i);
        sys_rst_i <= 1'b1;
        sw        <= s;
        repeat (4) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        repeat (20) @(posedge clk_sys_i);
        sw <= ~s;
        check(res, RES_EXP[~s[7:5]]);
        steps(4'b0000, 1);
        check(phase, dyn);
        repeat (IDLE_N) @(posedge clk_sys_i);
        check(phase, s[4] ? dyn : dyn >> 1);
        check(res, RES_EXP[~s[7:5]]);
    endtask : do_reset

    // Result watcher for bus answers and step pulses
    always @(posedge clk_sys_i) begin
        if (rsp.ack === 1'b1) begin
            if (exp_val.size() == 0) begin
                check(32'h1, 32'h0);
            end else begin
                check(rsp.dat & exp_msk[0], exp_val[0] & exp_msk[0]);
                void'(exp_val.pop_front());
                void'(exp_msk.pop_front());
            end
        end
        if (step === 1'b1) begin
            if (exp_dir.size() == 0) begin
                check(32'h1, 32'h0);
            end else begin
                check(dir, exp_dir.pop_front());
            end
        end
    end

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        void'($urandom(32'h947a1f0a));
        for (int i = 0; i < 4; i++) begin
            pick = 8'($urandom());
            if (i == 0) pick[3:0] = 4'h0;
            if (i == 3) pick[3:0] = 4'hf;
            pick[4] = i[0];
            do_reset(pick);
        end
        steps(4'b0001, 3);
        wb(1'b0, ADDR_POS, 32'h2, 32'hffffffff);
        ena_chk(1'b1, 1'b1);
        ena_chk(1'b0, 1'b0);
        wb(1'b1, ADDR_CTRL, 32'h2, 32'h0);
        fall <= 1'b1;
        steps(4'b0001, 2);
        wb(1'b1, ADDR_CTRL, 32'h1, 32'h0);
        fall <= 1'b0;
        dual <= 1'b1;
        steps(4'b0010, 2);
        wb(1'b1, ADDR_CTRL, 32'h4, 32'h0);
        dual <= 1'b0;
        fall <= 1'b1;
        ena_chk(1'b0, 1'b1);
        ena_chk(1'b1, 1'b0);
        steps(4'b0000, 1);
        wb(1'b1, ADDR_CFG_CUR, 32'h0a, 32'h0);
        wb(1'b1, ADDR_CFG_RES, 32'hc8, 32'h0);
        wb(1'b1, ADDR_CTRL, 32'hc, 32'h0);
        steps(4'b0000, 1);
        check(res, 16'h00c8);
        check(phase, 7'h0a);
        wb(1'b1, ADDR_CFG_CUR, 32'h50, 32'h0);
        wb(1'b1, ADDR_CFG_RES, 32'hc800, 32'h0);
        wb(1'b1, ADDR_CFG_CUR, 32'h51, 32'h0);
        wb(1'b1, ADDR_CFG_RES, 32'hc7, 32'h0);
        wb(1'b0, ADDR_CFG_RES, 32'hc800, 32'hffff);
        wb(1'b0, ADDR_CFG_CUR, 32'h50, 32'h7f);
        wb(1'b0, ADDR_EFF, 32'h0050c800, 32'hffffffff);
        wb(1'b0, ADDR_CTRL, 32'hc, 32'hf);
        check(res, 16'hc800);
        check(phase, 7'h50);
        wb(1'b1, 8'h20, 32'h55, 32'h0);
        wb(1'b0, 8'h20, 32'h0, 32'hffffffff);
        repeat (4) @(posedge clk_sys_i);
        check(exp_dir.size(), 32'h0);
        check(exp_val.size(), 32'h0);
        report_and_stop();
    end
endmodule : tb
